// ### hdl/dcc_config_control.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dcc_consts.svh"
// Summary of operation
// R1: Run bit 1 starts instruction sequencing, 0 halts it.
// R2: Soft reset clears run bit and every interrupt status bit.
// R3: Soft reset returns instruction pointer to zero.
// R4: Soft reset bit clears itself two clocks after being written.
// R5: Writing auto-zero bit starts one long auto-zero cycle.
// R6: Writing full-calibration bit starts one full calibration cycle.
// R7: Standby bit high keeps converter in low-power standby.
// R8: Leaving standby returns to active only after power-up delay.
// R9: Tag select 0 puts instruction number in result bits 15:13.
// R10: Tag select 1 fills result bits 15:13 with sign copies.
// R11: Per-conversion auto-zero bit requests short auto-zero before each conversion.
// R12: Sync direction 0 makes sync pin input, 1 output.
// R13: Two-bit section field selects instruction RAM section.
// R14: Host keeps production-test bit zero in normal operation.
// R15: Diagnostic bit high requests diagnostic conversion.
// R16: Each read of FIFO location advances read pointer by one; a read of an empty FIFO leaves it unchanged.
// R17: Interrupt flag bit 2 marks FIFO fill condition reached.
// R18: Interrupt flag bit 0 marks a limit crossing.
// R19: Configuration bit layout D0 run through D11 diagnostic, top ignored.
module dcc_config_control
  import dcc_pkg::*;
#(
  parameter int NUM_INSTR  = 8,
  parameter int FIFO_DEPTH = 32,
  parameter int FIFO_FILL  = 32
) (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        conv_valid_in,
  input  wire logic [12:0] conv_data_in,
  input  wire logic        limit_cross_in,
  input  wire logic        cal_done_in,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe_out,
  output logic             run_out,
  output logic             az_long_start_out,
  output logic             full_cal_start_out,
  output logic             standby_out,
  output logic             active_out,
  output logic             az_each_out,
  output logic [1:0]       section_out,
  output logic             test_mode_out,
  output logic             diag_out,
  output logic [2:0]       instr_ptr_out,
  output logic             irq_out
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  // ===================================================================
  // Register bus
  dcc_bus_state_type wr_state;
  dcc_bus_state_type rd_state;
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_commit;
  logic              rd_take;
  logic [7:0]        next_rd_data_sel;

  dcc_cfg_type       cfg;
  logic [15:0]       cfg_wr_val;
  logic [1:0]        srst_cnt;
  logic [`DCC_INT_W-1:0] int_flags;
  logic [`DCC_INT_W-1:0] int_mask;
  logic [`DCC_INT_W-1:0] int_events;
  logic [15:0]       pwrup_cnt;
  logic              sync_meta;
  logic              sync_sync;
  logic              sync_seen;

  logic [15:0]       fifo_mem [FIFO_DEPTH];
  logic [PTR_W:0]    fifo_wptr;
  logic [PTR_W:0]    fifo_rptr;
  logic [PTR_W:0]    fifo_count;
  logic              fifo_empty;
  logic              fifo_full;
  logic              fifo_push;
  logic              fifo_pop;
  logic [15:0]       tagged_result;

  assign s_axi_awready_out = (wr_state == DCC_BUS_IDLE) && !aw_held;
  assign s_axi_wready_out  = (wr_state == DCC_BUS_IDLE) && !w_held;
  assign s_axi_arready_out = (rd_state == DCC_BUS_IDLE);
  assign wr_commit         = (wr_state == DCC_BUS_IDLE) && aw_held && w_held;
  assign rd_take           = s_axi_arvalid_in && s_axi_arready_out;
  assign next_rd_data_sel  = s_axi_araddr_in;

  // Address and data are captured independently, in either order
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end else if (wr_commit) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end else if (wr_commit) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wr_state         <= DCC_BUS_IDLE;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `DCC_RESP_OKAY;
    end else begin
      case (wr_state)
        DCC_BUS_IDLE: begin
          if (wr_commit) begin
            wr_state         <= DCC_BUS_RESP;
            s_axi_bvalid_out <= 1'b1;
            if (aw_addr == `DCC_OFS_CONFIG || aw_addr == `DCC_OFS_INT_MASK) begin
              s_axi_bresp_out <= `DCC_RESP_OKAY;
            end else begin
              s_axi_bresp_out <= `DCC_RESP_SLVERR;
            end
          end
        end
        default: begin
          if (s_axi_bready_in) begin
            wr_state         <= DCC_BUS_IDLE;
            s_axi_bvalid_out <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rd_state         <= DCC_BUS_IDLE;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out  <= `DCC_RESP_OKAY;
      s_axi_rdata_out  <= 32'h0000_0000;
    end else begin
      case (rd_state)
        DCC_BUS_IDLE: begin
          if (rd_take) begin
            rd_state         <= DCC_BUS_RESP;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= `DCC_RESP_OKAY;
            if (next_rd_data_sel == `DCC_OFS_CONFIG) begin
              s_axi_rdata_out <= {16'h0000, cfg};
            end else if (next_rd_data_sel == `DCC_OFS_INT_FLAGS) begin
              s_axi_rdata_out <= {29'h0, int_flags};
            end else if (next_rd_data_sel == `DCC_OFS_INT_MASK) begin
              s_axi_rdata_out <= {29'h0, int_mask};
            end else if (next_rd_data_sel == `DCC_OFS_FIFO) begin
              s_axi_rdata_out <= fifo_empty ? 32'h0000_0000 : {16'h0000, fifo_mem[fifo_rptr[PTR_W-1:0]]};
            end else if (next_rd_data_sel == `DCC_OFS_CORE_STAT) begin
              s_axi_rdata_out <= {19'h0, sync_seen, 3'h0, 1'(fifo_count), fifo_full, fifo_empty,
                                  active_out, cfg.standby, cfg.run, instr_ptr_out};
            end else begin
              s_axi_rdata_out <= 32'h0000_0000;
              s_axi_rresp_out <= `DCC_RESP_SLVERR;
            end
          end
        end
        default: begin
          if (s_axi_rready_in) begin
            rd_state         <= DCC_BUS_IDLE;
            s_axi_rvalid_out <= 1'b0;
          end
        end
      endcase
    end
  end

  // ===================================================================
  // Configuration register
  assign cfg_wr_val = {w_strb[1] ? w_data[15:8] : cfg[15:8], w_strb[0] ? w_data[7:0] : cfg[7:0]};

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cfg                <= dcc_cfg_type'(`DCC_CFG_RESET);
      srst_cnt           <= 2'd0;
      az_long_start_out  <= 1'b0;
      full_cal_start_out <= 1'b0;
    end else begin
      az_long_start_out  <= 1'b0;
      full_cal_start_out <= 1'b0;
      if (wr_commit && aw_addr == `DCC_OFS_CONFIG) begin
        cfg          <= dcc_cfg_type'(cfg_wr_val);             // [R19]
        cfg.unused   <= 4'h0;                                  // [R19]
        cfg.az_long  <= 1'b0;
        cfg.full_cal <= 1'b0;
        az_long_start_out  <= cfg_wr_val[`DCC_CFG_AZ_LONG];    // [R5]
        full_cal_start_out <= cfg_wr_val[`DCC_CFG_FULL_CAL];   // [R6]
        srst_cnt     <= 2'd0;
        if (cfg_wr_val[`DCC_CFG_SRST]) begin
          cfg.run <= 1'b0;                                     // [R2]
        end
      end else if (cfg.soft_rst) begin
        cfg.run <= 1'b0;                                       // [R2]
        if (srst_cnt == 2'(`DCC_SRST_CYCLES - 1)) begin
          cfg.soft_rst <= 1'b0;                                // [R4]
          srst_cnt     <= 2'd0;
        end else begin
          srst_cnt <= srst_cnt + 2'd1;
        end
      end
    end
  end

  assign run_out       = cfg.run;                              // [R1]
  assign standby_out   = cfg.standby;                          // [R7]
  assign az_each_out   = cfg.az_each;                          // [R11]
  assign section_out   = cfg.section;                          // [R13]
  assign test_mode_out = cfg.test;
  assign diag_out      = cfg.diag;                             // [R15]
  assign sync_oe_out   = cfg.sync_dir;                         // [R12]

  // ===================================================================
  // Standby and power-up delay
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pwrup_cnt  <= 16'h0000;
      active_out <= 1'b0;
    end else if (cfg.standby) begin
      pwrup_cnt  <= 16'h0000;
      active_out <= 1'b0;                                      // [R7]
    end else if (!active_out) begin
      if (pwrup_cnt == 16'(`DCC_PWRUP_CYCLES - 1)) begin
        active_out <= 1'b1;                                    // [R8]
      end else begin
        pwrup_cnt <= pwrup_cnt + 16'h0001;
      end
    end
  end

  // ===================================================================
  // Instruction sequencing, result tagging, sync pin
  assign fifo_push     = conv_valid_in && cfg.run && active_out && !fifo_full;
  // Conversions that arrive with the FIFO full are dropped, not overwritten
  assign tagged_result = cfg.tag_sel ? {{3{conv_data_in[12]}}, conv_data_in}   // [R10]
                                     : {instr_ptr_out, conv_data_in};           // [R9]

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || cfg.soft_rst) begin
      instr_ptr_out <= 3'h0;                                   // [R3]
    end else if (conv_valid_in && cfg.run && active_out) begin
      instr_ptr_out <= (instr_ptr_out == 3'(NUM_INSTR - 1)) ? 3'h0 : instr_ptr_out + 3'h1; // [R1]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
      sync_seen <= 1'b0;
      sync_out  <= 1'b0;
    end else begin
      sync_meta <= sync_in;
      sync_sync <= sync_meta;
      sync_seen <= !cfg.sync_dir && sync_sync;                 // [R12]
      sync_out  <= cfg.sync_dir && fifo_push;                  // [R12]
    end
  end

  // ===================================================================
  // Result FIFO
  assign fifo_count = fifo_wptr - fifo_rptr;
  assign fifo_empty = (fifo_count == '0);
  assign fifo_full  = (fifo_count == (PTR_W+1)'(FIFO_DEPTH));
  assign fifo_pop   = rd_take && next_rd_data_sel == `DCC_OFS_FIFO && !fifo_empty;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || cfg.soft_rst) begin
      fifo_wptr <= '0;
      fifo_rptr <= '0;
    end else begin
      if (fifo_push) begin
        fifo_mem[fifo_wptr[PTR_W-1:0]] <= tagged_result;
        fifo_wptr <= fifo_wptr + 1'b1;
      end
      if (fifo_pop) begin
        fifo_rptr <= fifo_rptr + 1'b1;                         // [R16]
      end
    end
  end

  // ===================================================================
  // Interrupt flags, read-to-clear; a new event beats the clear
  always_comb begin
    int_events = '0;
    int_events[`DCC_INT_LIMIT]     = limit_cross_in;                             // [R18]
    int_events[`DCC_INT_CAL_DONE]  = cal_done_in;
    int_events[`DCC_INT_FIFO_FILL] = (fifo_count >= (PTR_W+1)'(FIFO_FILL));      // [R17]
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      int_flags <= '0;
      int_mask  <= `DCC_INT_MASK_RESET;
    end else begin
      if (cfg.soft_rst) begin
        int_flags <= '0;                                       // [R2]
      end else if (rd_take && next_rd_data_sel == `DCC_OFS_INT_FLAGS) begin
        int_flags <= int_events;
      end else begin
        int_flags <= int_flags | int_events;
      end
      if (wr_commit && aw_addr == `DCC_OFS_INT_MASK && w_strb[0]) begin
        int_mask <= w_data[`DCC_INT_W-1:0];
      end
    end
  end

  assign irq_out = |(int_flags & int_mask);

  // ===================================================================
  // Checks
  default clocking dcc_cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence srst_written;
    wr_commit && aw_addr == `DCC_OFS_CONFIG && cfg_wr_val[`DCC_CFG_SRST];
  endsequence

  sequence srst_two_cycles;
    cfg.soft_rst ##1 cfg.soft_rst ##1 !cfg.soft_rst;
  endsequence

  a_srst_self_clear: assert property (srst_written |=> srst_two_cycles) // [R4]
    else $error("soft reset did not clear after two cycles");
  a_srst_kills_run: assert property (srst_written |=> !run_out ##1 !run_out) // [R2]
    else $error("run stayed set during soft reset");
  a_srst_ptr_zero: assert property (srst_written |=> ##1 instr_ptr_out == 3'h0) // [R3]
    else $error("instruction pointer not zero after soft reset");
  a_srst_flags_zero: assert property (srst_written |=> ##1 int_flags == '0) // [R2]
    else $error("interrupt flags survived soft reset");
  a_az_long_pulse: assert property (wr_commit && aw_addr == `DCC_OFS_CONFIG
                                    && cfg_wr_val[`DCC_CFG_AZ_LONG] |=> az_long_start_out ##1 !az_long_start_out) // [R5]
    else $error("long auto-zero start not a single pulse");
  a_cal_pulse: assert property (full_cal_start_out |-> $past(wr_commit) && $past(aw_addr) == `DCC_OFS_CONFIG) // [R6]
    else $error("calibration start without configuration write");
  a_standby_inactive: assert property (standby_out |=> !active_out) // [R7]
    else $error("active while in standby");
  a_pwrup_delay: assert property ($fell(standby_out) |-> !active_out [*8]) // [R8]
    else $error("active too soon after standby release");
  a_tag_ptr: assert property (fifo_push && !cfg.tag_sel |=> fifo_mem[$past(fifo_wptr[PTR_W-1:0])][15:13]
                              == $past(instr_ptr_out)) // [R9]
    else $error("instruction tag missing from result");
  a_tag_sign: assert property (fifo_push && cfg.tag_sel |=> fifo_mem[$past(fifo_wptr[PTR_W-1:0])][15:13]
                               == {3{$past(conv_data_in[12])}}) // [R10]
    else $error("sign extension missing from result");
  a_fifo_pop: assert property (fifo_pop && !fifo_push |=> fifo_count == $past(fifo_count) - 1'b1) // [R16]
    else $error("FIFO read did not advance pointer");
  a_fill_flag: assert property (fifo_count >= (PTR_W+1)'(FIFO_FILL) && !cfg.soft_rst |=> int_flags[`DCC_INT_FIFO_FILL]) // [R17]
    else $error("fill flag not set");
  a_limit_flag: assert property (limit_cross_in && !cfg.soft_rst |=> int_flags[`DCC_INT_LIMIT]) // [R18]
    else $error("limit flag not set");
  a_sync_dir: assert property (sync_out |-> sync_oe_out) // [R12]
    else $error("sync driven while configured as input");

endmodule // dcc_config_control

// ### hdl/dcc_consts.svh
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// =====================================================================
// Register map (byte addresses)
`define DCC_ADDR_W          8
`define DCC_OFS_CONFIG      8'h00
`define DCC_OFS_INT_FLAGS   8'h04
`define DCC_OFS_INT_MASK    8'h08
`define DCC_OFS_FIFO        8'h0c
`define DCC_OFS_CORE_STAT   8'h10

// =====================================================================
// Configuration field positions and reset value
`define DCC_CFG_RUN         0
`define DCC_CFG_SRST        1
`define DCC_CFG_AZ_LONG     2
`define DCC_CFG_FULL_CAL    3
`define DCC_CFG_STANDBY     4
`define DCC_CFG_TAG_SEL     5
`define DCC_CFG_AZ_EACH     6
`define DCC_CFG_SYNC_DIR    7
`define DCC_CFG_TEST        10
`define DCC_CFG_DIAG        11
`define DCC_CFG_RESET       16'h0000

// =====================================================================
// Interrupt flag positions
`define DCC_INT_LIMIT       0
`define DCC_INT_CAL_DONE    1
`define DCC_INT_FIFO_FILL   2
`define DCC_INT_W           3
`define DCC_INT_MASK_RESET  3'h0

// =====================================================================
// Timing
`define DCC_CLK_PERIOD_NS   10
`define DCC_SRST_CYCLES     2
`define DCC_PWRUP_NS        10000
`define DCC_PWRUP_CYCLES    ((`DCC_PWRUP_NS + `DCC_CLK_PERIOD_NS - 1) / `DCC_CLK_PERIOD_NS)

// =====================================================================
// AXI responses
`define DCC_RESP_OKAY       2'b00
`define DCC_RESP_SLVERR     2'b10

`endif

// ### hdl/dcc_pkg.sv
package dcc_pkg;

  typedef struct packed {
    logic [3:0] unused;
    logic       diag;
    logic       test;
    logic [1:0] section;
    logic       sync_dir;
    logic       az_each;
    logic       tag_sel;
    logic       standby;
    logic       full_cal;
    logic       az_long;
    logic       soft_rst;
    logic       run;
  } dcc_cfg_type;

  typedef struct packed {
    logic        valid;
    logic [12:0] data;
  } dcc_conv_type;

  typedef enum logic [1:0] {
    DCC_BUS_IDLE = 2'b00,
    DCC_BUS_RESP = 2'b01
  } dcc_bus_state_type;

endpackage

// ### test/dcc_conv_model.sv
`timescale 1ns/1ps
// ==========================================
// Converter core stand-in
module dcc_conv_model #(
  parameter int CAL_CYC = 20
) (
  input  wire logic        mclk_in,
  input  wire logic        run_in,
  input  wire logic        active_in,
  input  wire logic        az_each_in,
  input  wire logic        az_start_in,
  input  wire logic        cal_start_in,
  input  wire logic        req_in,
  input  wire logic [12:0] req_data_in,
  output logic             conv_valid_out,
  output logic [12:0]      conv_data_out,
  output logic             cal_done_out
);
  int          wait_q = 0;
  int          cal_q  = 0;
  logic [12:0] dat_q  = '0;

  initial begin
    conv_valid_out = 1'b0;
    conv_data_out  = '0;
    cal_done_out   = 1'b0;
  end

  always @(posedge mclk_in) begin
    conv_valid_out <= 1'b0;
    // Released bus never repeats the last result
    if (conv_valid_out) conv_data_out <= ~conv_data_out;
    if (req_in) begin
      wait_q <= az_each_in ? 6 : 3;
      dat_q  <= req_data_in;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end else if (wait_q == 1) begin
      wait_q <= 0;
      if (run_in && active_in) begin
        conv_valid_out <= 1'b1;
        conv_data_out  <= dat_q;
      end
    end
  end

  always @(posedge mclk_in) begin
    cal_done_out <= 1'b0;
    if (az_start_in || cal_start_in) begin
      cal_q <= CAL_CYC;
    end else if (cal_q > 1) begin
      cal_q <= cal_q - 1;
    end else if (cal_q == 1) begin
      cal_q        <= 0;
      cal_done_out <= 1'b1;
    end
  end
endmodule // dcc_conv_model

// ### test/dcc_config_control_tb_top.sv
`timescale 1ns/1ps
`include "dcc_consts.svh"
`define CHK(nm, ex, ac) begin n_compared++; if ((ac) !== (ex)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, ac); end end
module dcc_config_control_tb_top
  import dcc_pkg::*;
;
  localparam int         PWRUP = `DCC_PWRUP_CYCLES;
  localparam logic [7:0] CFG   = `DCC_OFS_CONFIG;
  localparam logic [7:0] FLG   = `DCC_OFS_INT_FLAGS;
  localparam logic [7:0] MSK   = `DCC_OFS_INT_MASK;
  localparam logic [7:0] FIF   = `DCC_OFS_FIFO;
  localparam logic [7:0] CST   = `DCC_OFS_CORE_STAT;
  localparam logic [1:0] OK    = `DCC_RESP_OKAY;
  localparam logic [1:0] SE    = `DCC_RESP_SLVERR;
  logic mclk, rst, awvalid, wvalid, bready, arvalid, rready, lim_in, sync_in, req;
  logic awready, wready, bvalid, arready, rvalid, conv_valid, cal_done, sync_out, sync_oe;
  logic run, az_st, cal_st, standby, active, az_each, test_mode, diag, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, section;
  logic [12:0] conv_data, req_data;
  logic [2:0]  iptr;
  dcc_cfg_type cfg;
  int error_cnt = 0, n_compared = 0, cyc_n = 0, n_az = 0, n_cal = 0, n_sync = 0, rel;

  dcc_config_control #(.NUM_INSTR(8), .FIFO_DEPTH(8), .FIFO_FILL(3)) dut (
    .mclk_in(mclk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .conv_valid_in(conv_valid), .conv_data_in(conv_data), .limit_cross_in(lim_in),
    .cal_done_in(cal_done), .sync_in(sync_in), .sync_out(sync_out), .sync_oe_out(sync_oe),
    .run_out(run), .az_long_start_out(az_st), .full_cal_start_out(cal_st),
    .standby_out(standby), .active_out(active), .az_each_out(az_each), .section_out(section),
    .test_mode_out(test_mode), .diag_out(diag), .instr_ptr_out(iptr), .irq_out(irq));

  dcc_conv_model u_conv (
    .mclk_in(mclk), .run_in(run), .active_in(active), .az_each_in(az_each),
    .az_start_in(az_st), .cal_start_in(cal_st), .req_in(req), .req_data_in(req_data),
    .conv_valid_out(conv_valid), .conv_data_out(conv_data), .cal_done_out(cal_done));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc_n++;
    if (az_st === 1'b1) n_az++;
    if (cal_st === 1'b1) n_cal++;
    if (sync_out === 1'b1) n_sync++;
  end

  // ==========================================
  // Bus access, sampled at the falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   t;
    logic ha, hw, hb;
    t = 0;
    hb = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!hb && t < 50) begin
      @(negedge mclk);
      t++;
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      if (hb) `CHK("bresp", er, bresp)
      @(posedge mclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!hb) `CHK("bvalid", 1'b1, hb)
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int   t;
    logic ha, hr;
    t = 0;
    hr = 1'b0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!hr && t < 50) begin
      @(negedge mclk);
      t++;
      ha = arvalid & arready;
      hr = rvalid;
      if (hr) `CHK("rdata", ex, rdata)
      if (hr) `CHK("rresp", er, rresp)
      @(posedge mclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!hr) `CHK("rvalid", 1'b1, hr)
  endtask

  task automatic conv(input logic [12:0] d);
    @(posedge mclk);
    req      <= 1'b1;
    req_data <= d;
    @(posedge mclk);
    req <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask

  task automatic limit_pulse;
    @(posedge mclk);
    lim_in <= 1'b1;
    @(posedge mclk);
    lim_in <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  // Delay is measured from the end of the releasing access, hence the slack
  task automatic wait_active;
    int t;
    t = 0;
    while (active !== 1'b1 && t < 2000) begin
      @(negedge mclk);
      t++;
    end
    `CHK("pwrup", 1'b1, (cyc_n - rel >= PWRUP - 5) && (cyc_n - rel <= PWRUP + 5))
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end

  // ==========================================
  // Scenarios
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, lim_in, sync_in, req} = 9'h100;
    {awaddr, araddr, wdata, req_data} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    rel = cyc_n;
    `CHK("run", 1'b0, run)
    rc(CFG, 32'h0, OK);
    rc(MSK, 32'h0, OK);
    rc(8'h14, 32'h0, SE);
    wr(8'h14, 32'h1, SE);
    wr(FLG, 32'h7, SE);
    wait_active();
    cfg = '0;
    cfg.standby = 1'b1;
    wr(CFG, {16'h0, cfg}, OK);
    repeat (2) @(negedge mclk);
    `CHK("standby", 1'b1, standby)
    `CHK("active", 1'b0, active)
    wr(CFG, 32'h0, OK);
    @(negedge mclk);
    rel = cyc_n;
    wait_active();
    wr(CFG, 32'h0000_f9e1, OK);
    @(negedge mclk);
    `CHK("run", 1'b1, run)
    `CHK("az_each", 1'b1, az_each)
    `CHK("sync_oe", 1'b1, sync_oe)
    `CHK("diag", 1'b1, diag)
    `CHK("test", 1'b0, test_mode)
    rc(CFG, 32'h0000_09e1, OK);
    for (int s = 0; s < 4; s++) begin
      wr(CFG, {22'h0, s[1:0], 8'h00}, OK);
      @(negedge mclk);
      `CHK("section", s[1:0], section)
      rc(CFG, {22'h0, s[1:0], 8'h00}, OK);
    end
    wr(CFG, 32'h4, OK);
    rc(CFG, 32'h0, OK);
    `CHK("az_pulses", 1, n_az)
    repeat (25) @(posedge mclk);
    rc(FLG, 32'h2, OK);
    wr(CFG, 32'h8, OK);
    repeat (25) @(posedge mclk);
    `CHK("cal_pulses", 1, n_cal)
    rc(FLG, 32'h2, OK);
    wr(CFG, 32'h81, OK);
    conv(13'h0123);
    conv(13'h1abc);
    conv(13'h0005);
    `CHK("sync_pulses", 3, n_sync)
    rc(FLG, 32'h4, OK);
    rc(FIF, 32'h0123, OK);
    rc(FIF, 32'h3abc, OK);
    rc(FIF, 32'h4005, OK);
    rc(FIF, 32'h0, OK);
    rc(FLG, 32'h4, OK);
    wr(CFG, 32'h61, OK);
    conv(13'h1abc);
    conv(13'h0abc);
    rc(FIF, 32'hfabc, OK);
    rc(FIF, 32'h0abc, OK);
    wr(CFG, 32'h0, OK);
    conv(13'h0055);
    rc(FIF, 32'h0, OK);
    `CHK("iptr", 3'd5, iptr)
    wr(MSK, 32'h1, OK);
    limit_pulse();
    `CHK("irq", 1'b1, irq)
    rc(FLG, 32'h1, OK);
    @(negedge mclk);
    `CHK("irq", 1'b0, irq)
    wr(MSK, 32'h0, OK);
    limit_pulse();
    `CHK("irq", 1'b0, irq)
    wr(CFG, 32'h3, OK);
    @(negedge mclk);
    `CHK("run", 1'b0, run)
    `CHK("iptr", 3'd0, iptr)
    rc(CFG, 32'h0, OK);
    rc(FLG, 32'h0, OK);
    @(posedge mclk);
    sync_in <= 1'b1;
    repeat (4) @(posedge mclk);
    rc(CST, 32'h0000_1060, OK);
    `CHK("sync_oe", 1'b0, sync_oe)
    print_verdict();
  end
endmodule // dcc_config_control_tb_top
